/* File: hdl/crod_ctl_if.sv */
// control bundle from the decoder to the glitch filter and cycle clock
`timescale 1ns/1ps
interface crod_ctl_if;
	logic clock_en;
	logic filt_on;
	logic filt_short;
	logic cyc_four;
	logic clkout_en;
	logic clkout_pp;

	modport ctl  (output clock_en, output filt_on, output filt_short,
	              output cyc_four, output clkout_en, output clkout_pp);
	modport filt (input clock_en, input filt_on, input filt_short);
	modport cyc  (input clock_en, input cyc_four, input clkout_en, input clkout_pp);
endinterface : crod_ctl_if

/* File: hdl/crod_cycle_clk.sv */
// instruction cycle clock and its optional drive onto the oscillator input pin
`timescale 1ns/1ps
`include "crod_regs.svh"
module crod_cycle_clk (
	input  wire logic clock,
	input  wire logic reset_n,
	crod_ctl_if.cyc   ctl,
	output logic      instr_clk,
	output logic      pin_out,
	output logic      pin_oe_n
);
	logic [1:0] half_r;
	logic [1:0] half_lim;

	// half a cycle in oscillator periods, minus one
	assign half_lim = ctl.cyc_four ? 2'(`CROD_CYC_LONG / 2 - 1) : 2'(`CROD_CYC_SHORT / 2 - 1);

	// toggle at every half cycle so the duty stays at one half
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			half_r    <= 2'h0;
			instr_clk <= 1'b0;
		end else if (ctl.clock_en) begin
			if (half_r >= half_lim) begin
				half_r    <= 2'h0;
				instr_clk <= ~instr_clk;
			end else begin
				half_r <= half_r + 2'h1;
			end
		end
	end

	// pin drive lags the cycle clock by one period; oe_n low means driven
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_out  <= 1'b0;
			pin_oe_n <= 1'b1;
		end else if (ctl.clock_en) begin
			if (!ctl.clkout_en) begin
				pin_out  <= 1'b0;
				pin_oe_n <= 1'b1;
			end else if (ctl.clkout_pp) begin
				pin_out  <= instr_clk;
				pin_oe_n <= 1'b0;
			end else begin
				pin_out  <= 1'b0;
				pin_oe_n <= instr_clk;
			end
		end
	end
endmodule : crod_cycle_clk

/* File: hdl/crod_glitch_filter.sv */
// noise rejection filter for the shared reset/port pin
`timescale 1ns/1ps
`include "crod_regs.svh"
module crod_glitch_filter (
	input  wire logic clock,
	input  wire logic reset_n,
	crod_ctl_if.filt  ctl,
	input  wire logic pin_in,
	output logic      pin_out
);
	logic       sync1_r;
	logic       sync2_r;
	logic [4:0] cnt_r;
	logic [4:0] lim;

	// two-flop synchroniser, idles high like an undriven reset pin
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else if (ctl.clock_en) begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// last count before a new level is accepted
	assign lim = ctl.filt_short ? 5'(`CROD_GLITCH_SHORT - 1) : 5'(`CROD_GLITCH_LONG - 1);

	// a level change must hold for the full width or it is dropped
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_out <= 1'b1;
			cnt_r   <= 5'h00;
		end else if (ctl.clock_en) begin
			if (!ctl.filt_on) begin
				pin_out <= sync2_r;
				cnt_r   <= 5'h00;
			end else if (sync2_r == pin_out) begin
				cnt_r <= 5'h00;
			end else if (cnt_r == lim) begin
				pin_out <= sync2_r;
				cnt_r   <= 5'h00;
			end else begin
				cnt_r <= cnt_r + 5'h01;
			end
		end
	end
endmodule : crod_glitch_filter

/* File: hdl/crod_pkg.sv */
// types shared by the option decoder modules
package crod_pkg;

	typedef enum logic [3:0] {
		ST_FILL1 = 4'b0001,
		ST_FILL2 = 4'b0010,
		ST_LATCH = 4'b0100,
		ST_RUN   = 4'b1000
	} crod_state_t;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_GREEN  = 2'b01,
		MODE_IDLE   = 2'b10,
		MODE_SLEEP  = 2'b11
	} crod_mode_t;

	typedef enum logic [1:0] {
		LVR_4V0  = 2'b00,
		LVR_3V5  = 2'b01,
		LVR_2V7  = 2'b10,
		LVR_NONE = 2'b11
	} crod_lvr_t;

endpackage : crod_pkg

/* File: hdl/crod_regs.svh */
// register offsets, option word field positions, reset values and counts
`ifndef CROD_REGS_SVH
`define CROD_REGS_SVH

// avalon byte offsets
`define CROD_OFF_WORD0      8'h00
`define CROD_OFF_WORD1      8'h04
`define CROD_OFF_MODE       8'h08
`define CROD_OFF_STATUS     8'h0C
`define CROD_OFF_FREQ       8'h10

// option word 0 fields
`define CROD_W0_RUN_MODE    10
`define CROD_W0_POWER       9
`define CROD_W0_LVR_HI      8
`define CROD_W0_LVR_LO      7
`define CROD_W0_RST_PIN     6
`define CROD_W0_WDT_N       5
`define CROD_W0_GLITCH_W    4
`define CROD_W0_GLITCH_EN   3

// option word 1 fields
`define CROD_W1_SUB_CLK     13
`define CROD_W1_TRIM_HI     12
`define CROD_W1_TRIM_LO     7
`define CROD_W1_RCF_HI      6
`define CROD_W1_RCF_LO      5
`define CROD_W1_OSC_HI      3
`define CROD_W1_OSC_LO      1
`define CROD_W1_CLK_DRV     0

// status register fields
`define CROD_ST_VALID       0
`define CROD_ST_FILT_ON     1
`define CROD_ST_IRC         2
`define CROD_ST_CLKOUT      3
`define CROD_ST_LVR_EN      4
`define CROD_ST_OSC_LO      5
`define CROD_ST_OSC_HI      7
`define CROD_ST_WDT_EN      8
`define CROD_ST_RST_EXT     9
`define CROD_ST_CYC4        10

// reset values of the latched option words
`define CROD_WORD0_RST      15'h27FF
`define CROD_WORD1_RST      15'h7FE7

// oscillator mode codes
`define CROD_OSC_HXT_FAST   3'h7
`define CROD_OSC_HXT_MID    3'h6
`define CROD_OSC_XT_MID     3'h5
`define CROD_OSC_XT_LOW     3'h4
`define CROD_OSC_IRC_IO     3'h3
`define CROD_OSC_IRC_OUT    3'h2

// nominal frequencies in khz
`define CROD_IRC_1M_KHZ     16'h03E8
`define CROD_IRC_8M_KHZ     16'h1F40
`define CROD_IRC_16M_KHZ    16'h3E80
`define CROD_IRC_4M_KHZ     16'h0FA0
`define CROD_SUB_32K_KHZ    16'h0020
`define CROD_SUB_16K_KHZ    16'h0010

// glitch widths and instruction cycle lengths in main clock periods
`define CROD_GLITCH_LONG    32
`define CROD_GLITCH_SHORT   8
`define CROD_CYC_SHORT      2
`define CROD_CYC_LONG       4

`endif

/* File: hdl/crod_top.sv */
// clock and reset option decoder: latches the option words at reset and decodes them
//
// Operation
// - reset run mode option 0 starts the core in green mode, 1 (default) in normal mode.
// - power level option 0 selects low-power operation for clocks up to 400 kHz, 1 normal power.
// - brownout level 00 is 4.0 V, 01 is 3.5 V, 10 is 2.7 V, and 11 leaves only power-on reset.
// - reset pin option 0 makes the shared pin an active-low reset, 1 (default) a port bit.
// - watchdog enable is active low: 0 enables the watchdog, 1 (default) disables it.
// - glitch width option 1 (default) needs 32 main clock periods, 0 needs 8.
// - in low-frequency crystal mode the filter always uses 8 periods.
// - glitch filter enable 0 turns the filter off, 1 (default) turns it on.
// - in green, idle and sleep mode the filter is bypassed whatever the enable says.
// - sub clock option 0 runs the sub oscillator at 32 kHz, 1 (default) at 16 kHz.
// - the six-bit rc trim is written by the programmer and only applied here.
// - rc frequency select 00 is 1 MHz, 01 is 8 MHz, 10 is 16 MHz, 11 (default) is 4 MHz.
// - oscillator codes 111, 110, 101 and 100 pick the four crystal ranges from fast to low.
// - codes 011 (default) and 010 pick the internal rc; 011 frees the pin, 010 drives the clock out.
// - the clock out is open drain when the drive option is 0 and push-pull when it is 1.
// - an instruction cycle lasts two oscillator periods, or four when the cycle length bit is high.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "crod_regs.svh"
module crod_top (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        clock_en,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [14:0] opt_word0,
	input  wire logic [14:0] opt_word1,
	input  wire logic        cycle_length_select,
	input  wire logic        shared_pin_in,
	output logic             cfg_valid,
	output logic      [1:0]  run_mode,
	output logic             low_power,
	output logic      [1:0]  brownout_level,
	output logic             brownout_enable,
	output logic             ext_reset_n,
	output logic             shared_port_bit,
	output logic             watchdog_enable,
	output logic             sub_clock_32k,
	output logic      [15:0] sub_clock_freq_khz,
	output logic      [5:0]  internal_rc_trim,
	output logic      [1:0]  internal_rc_freq_select,
	output logic      [15:0] main_clock_freq_khz,
	output logic      [2:0]  osc_mode_select,
	output logic             internal_rc_mode,
	output logic             crystal_low_mode,
	output logic             osc_in_gpio,
	output logic             instr_clk,
	output logic             osc_in_pin_out,
	output logic             osc_in_pin_oe_n
);
	crod_ctl_if ctl_if ();

	crod_pkg::crod_state_t st_r;
	crod_pkg::crod_state_t st_nxt;
	crod_pkg::crod_mode_t  mode_r;

	logic [14:0] w0_s1_r;
	logic [14:0] w0_s2_r;
	logic [14:0] w1_s1_r;
	logic [14:0] w1_s2_r;
	logic        cyc_s1_r;
	logic        cyc_s2_r;
	logic [14:0] word0_r;
	logic [14:0] word1_r;
	logic        cyc_four_r;
	logic        wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_nxt;
	logic [31:0] status;
	logic        bus_req;
	logic        bus_done;
	logic        filt_pin;
	logic [2:0]  osc_code;
	logic        irc_sel;
	logic        clkout_sel;
	logic        low_xtal;
	logic        filt_on_nxt;
	logic [15:0] irc_khz;

	assign ctl_if.clock_en = clock_en;

	// option words come from the fuse array, outside this clock domain
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			w0_s1_r  <= `CROD_WORD0_RST;
			w0_s2_r  <= `CROD_WORD0_RST;
			w1_s1_r  <= `CROD_WORD1_RST;
			w1_s2_r  <= `CROD_WORD1_RST;
			cyc_s1_r <= 1'b0;
			cyc_s2_r <= 1'b0;
		end else if (clock_en) begin
			w0_s1_r  <= opt_word0;
			w0_s2_r  <= w0_s1_r;
			w1_s1_r  <= opt_word1;
			w1_s2_r  <= w1_s1_r;
			cyc_s1_r <= cycle_length_select;
			cyc_s2_r <= cyc_s1_r;
		end
	end

	// load sequence: two edges to fill the synchroniser, one to latch
	always_comb begin
		case (st_r)
			crod_pkg::ST_FILL1: st_nxt = crod_pkg::ST_FILL2;
			crod_pkg::ST_FILL2: st_nxt = crod_pkg::ST_LATCH;
			crod_pkg::ST_LATCH: st_nxt = crod_pkg::ST_RUN;
			crod_pkg::ST_RUN:   st_nxt = crod_pkg::ST_RUN;
			default:            st_nxt = crod_pkg::ST_FILL1;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= crod_pkg::ST_FILL1;
		end else if (clock_en) begin
			st_r <= st_nxt;
		end
	end

	// words are taken once per reset; a later fuse change cannot move the clock source
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			word0_r    <= `CROD_WORD0_RST;
			word1_r    <= `CROD_WORD1_RST;
			cyc_four_r <= 1'b0;
		end else if (clock_en && (st_r == crod_pkg::ST_LATCH)) begin
			word0_r    <= w0_s2_r;
			word1_r    <= w1_s2_r;
			cyc_four_r <= cyc_s2_r;
		end
	end

	// oscillator code decode; unused codes fall back to rc with a free pin
	assign osc_code   = word1_r[`CROD_W1_OSC_HI:`CROD_W1_OSC_LO];
	assign irc_sel    = (osc_code == `CROD_OSC_IRC_IO) || (osc_code == `CROD_OSC_IRC_OUT) || !osc_code[2];
	assign clkout_sel = (osc_code == `CROD_OSC_IRC_OUT);
	assign low_xtal   = (osc_code == `CROD_OSC_XT_LOW);

	// filter runs only in normal mode with its enable set
	assign filt_on_nxt = word0_r[`CROD_W0_GLITCH_EN] && (mode_r == crod_pkg::MODE_NORMAL);

	// nominal rc frequency from the two select bits
	always_comb begin
		case (word1_r[`CROD_W1_RCF_HI:`CROD_W1_RCF_LO])
			2'b00:   irc_khz = `CROD_IRC_1M_KHZ;
			2'b01:   irc_khz = `CROD_IRC_8M_KHZ;
			2'b10:   irc_khz = `CROD_IRC_16M_KHZ;
			default: irc_khz = `CROD_IRC_4M_KHZ;
		endcase
	end

	// run mode starts from the option bit, then software may move it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= crod_pkg::MODE_NORMAL;
		end else if (clock_en) begin
			if (st_r == crod_pkg::ST_LATCH) begin
				mode_r <= w0_s2_r[`CROD_W0_RUN_MODE] ? crod_pkg::MODE_NORMAL : crod_pkg::MODE_GREEN;
			end else if (bus_done && avs_write && (avs_address == `CROD_OFF_MODE) &&
			             avs_byteenable[0] && (st_r == crod_pkg::ST_RUN)) begin
				mode_r <= crod_pkg::crod_mode_t'(avs_writedata[1:0]);
			end
		end
	end

	// controls for the filter and the cycle clock
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctl_if.filt_on    <= 1'b0;
			ctl_if.filt_short <= 1'b0;
			ctl_if.cyc_four   <= 1'b0;
			ctl_if.clkout_en  <= 1'b0;
			ctl_if.clkout_pp  <= 1'b1;
		end else if (clock_en) begin
			ctl_if.filt_on    <= filt_on_nxt;
			ctl_if.filt_short <= !word0_r[`CROD_W0_GLITCH_W] || low_xtal;
			ctl_if.cyc_four   <= cyc_four_r;
			ctl_if.clkout_en  <= clkout_sel;
			ctl_if.clkout_pp  <= word1_r[`CROD_W1_CLK_DRV];
		end
	end

	// decoded system settings, all registered
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cfg_valid               <= 1'b0;
			low_power               <= 1'b0;
			brownout_level          <= crod_pkg::LVR_NONE;
			brownout_enable         <= 1'b0;
			watchdog_enable         <= 1'b0;
			sub_clock_32k           <= 1'b0;
			sub_clock_freq_khz      <= `CROD_SUB_16K_KHZ;
			internal_rc_trim        <= 6'h3F;
			internal_rc_freq_select <= 2'h3;
			main_clock_freq_khz     <= `CROD_IRC_4M_KHZ;
			osc_mode_select         <= `CROD_OSC_IRC_IO;
			internal_rc_mode        <= 1'b1;
			crystal_low_mode        <= 1'b0;
			osc_in_gpio             <= 1'b1;
		end else if (clock_en) begin
			cfg_valid       <= (st_r == crod_pkg::ST_RUN);
			low_power       <= !word0_r[`CROD_W0_POWER];
			brownout_level  <= word0_r[`CROD_W0_LVR_HI:`CROD_W0_LVR_LO];
			brownout_enable <= (word0_r[`CROD_W0_LVR_HI:`CROD_W0_LVR_LO] != crod_pkg::LVR_NONE);
			watchdog_enable <= !word0_r[`CROD_W0_WDT_N];
			sub_clock_32k   <= !word1_r[`CROD_W1_SUB_CLK];
			sub_clock_freq_khz <= word1_r[`CROD_W1_SUB_CLK] ? `CROD_SUB_16K_KHZ : `CROD_SUB_32K_KHZ;
			internal_rc_trim        <= word1_r[`CROD_W1_TRIM_HI:`CROD_W1_TRIM_LO];
			internal_rc_freq_select <= word1_r[`CROD_W1_RCF_HI:`CROD_W1_RCF_LO];
			// crystal frequency is set by the part on the pins, so it reads as zero
			main_clock_freq_khz <= irc_sel ? irc_khz : 16'h0000;
			osc_mode_select     <= osc_code;
			internal_rc_mode    <= irc_sel;
			crystal_low_mode    <= low_xtal;
			osc_in_gpio         <= irc_sel && !clkout_sel;
		end
	end

	// shared pin: filtered level goes to reset or to the port bit
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ext_reset_n     <= 1'b1;
			shared_port_bit <= 1'b0;
		end else if (clock_en) begin
			if (!word0_r[`CROD_W0_RST_PIN] && (st_r == crod_pkg::ST_RUN)) begin
				ext_reset_n     <= filt_pin;
				shared_port_bit <= 1'b0;
			end else begin
				ext_reset_n     <= 1'b1;
				shared_port_bit <= filt_pin;
			end
		end
	end

	crod_glitch_filter u_filter (
		.clock   (clock),
		.reset_n (reset_n),
		.ctl     (ctl_if.filt),
		.pin_in  (shared_pin_in),
		.pin_out (filt_pin)
	);

	crod_cycle_clk u_cycle (
		.clock     (clock),
		.reset_n   (reset_n),
		.ctl       (ctl_if.cyc),
		.instr_clk (instr_clk),
		.pin_out   (osc_in_pin_out),
		.pin_oe_n  (osc_in_pin_oe_n)
	);

	assign run_mode = mode_r;

	// status word shows the live decoded state
	always_comb begin
		status = 32'h0000_0000;
		status[`CROD_ST_VALID]   = cfg_valid;
		status[`CROD_ST_FILT_ON] = ctl_if.filt_on;
		status[`CROD_ST_IRC]     = internal_rc_mode;
		status[`CROD_ST_CLKOUT]  = ctl_if.clkout_en;
		status[`CROD_ST_LVR_EN]  = brownout_enable;
		status[`CROD_ST_OSC_HI:`CROD_ST_OSC_LO] = osc_mode_select;
		status[`CROD_ST_WDT_EN]  = watchdog_enable;
		status[`CROD_ST_RST_EXT] = !word0_r[`CROD_W0_RST_PIN];
		status[`CROD_ST_CYC4]    = ctl_if.cyc_four;
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (avs_address)
			`CROD_OFF_WORD0:  rd_nxt = {17'h0_0000, word0_r};
			`CROD_OFF_WORD1:  rd_nxt = {17'h0_0000, word1_r};
			`CROD_OFF_MODE:   rd_nxt = {30'h0000_0000, mode_r};
			`CROD_OFF_STATUS: rd_nxt = status;
			`CROD_OFF_FREQ:   rd_nxt = {sub_clock_freq_khz, main_clock_freq_khz};
			default:          rd_nxt = 32'h0000_0000;
		endcase
	end

	// avalon slave: waitrequest rests high and drops for one cycle per request
	assign bus_req  = avs_read || avs_write;
	assign bus_done = bus_req && !wait_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else if (clock_en) begin
			if (bus_req && wait_r) begin
				wait_r  <= 1'b0;
				rdata_r <= avs_read ? rd_nxt : 32'h0000_0000;
			end else begin
				wait_r <= 1'b1;
			end
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdata_r;
endmodule : crod_top

/* File: test/crod_top_props.sv */
// concurrent checks on the option decoder ports
`timescale 1ns/1ps
`include "crod_regs.svh"
module crod_top_props (
	input logic        clock,
	input logic        reset_n,
	input logic        clock_en,
	input logic        avs_read,
	input logic        avs_write,
	input logic        avs_waitrequest,
	input logic [14:0] opt_word0,
	input logic [14:0] opt_word1,
	input logic        cfg_valid,
	input logic [1:0]  run_mode,
	input logic        low_power,
	input logic [1:0]  brownout_level,
	input logic        brownout_enable,
	input logic        watchdog_enable,
	input logic        sub_clock_32k,
	input logic [15:0] sub_clock_freq_khz,
	input logic [5:0]  internal_rc_trim,
	input logic [1:0]  internal_rc_freq_select,
	input logic [15:0] main_clock_freq_khz,
	input logic [2:0]  osc_mode_select,
	input logic        internal_rc_mode,
	input logic        crystal_low_mode,
	input logic        osc_in_gpio,
	input logic        osc_in_pin_oe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// the moment the decoded set first appears; words are held static around it
	sequence s_latched;
		$rose(cfg_valid);
	endsequence

	chk_run_mode_start: assert property (s_latched |-> run_mode == (opt_word0[10] ? 2'h0 : 2'h1))
		else $error("run mode after reset wrong");
	chk_power_wdt_map: assert property (s_latched |-> low_power == !opt_word0[9] &&
		watchdog_enable == !opt_word0[5] && brownout_level == opt_word0[8:7]) else $error("word0 decode wrong");
	chk_brownout_enable: assert property (cfg_valid |-> brownout_enable == (brownout_level != 2'h3))
		else $error("brownout enable wrong");
	chk_sub_trim_map: assert property (s_latched |-> sub_clock_32k == !opt_word1[13] &&
		internal_rc_trim == opt_word1[12:7] && osc_mode_select == opt_word1[3:1]) else $error("word1 decode wrong");
	chk_rc_freq_table: assert property (cfg_valid && internal_rc_mode |->
		sub_clock_freq_khz == (sub_clock_32k ? `CROD_SUB_32K_KHZ : `CROD_SUB_16K_KHZ) && main_clock_freq_khz ==
		(internal_rc_freq_select == 2'h0 ? `CROD_IRC_1M_KHZ : internal_rc_freq_select == 2'h1 ? `CROD_IRC_8M_KHZ :
		internal_rc_freq_select == 2'h2 ? `CROD_IRC_16M_KHZ : `CROD_IRC_4M_KHZ)) else $error("frequency wrong");
	chk_osc_class: assert property (cfg_valid |-> internal_rc_mode == !osc_mode_select[2] &&
		crystal_low_mode == (osc_mode_select == 3'h4) &&
		osc_in_gpio == (!osc_mode_select[2] && osc_mode_select != 3'h2)) else $error("osc class wrong");
	chk_options_frozen: assert property (cfg_valid && $past(cfg_valid) |-> $stable(osc_mode_select) &&
		$stable(internal_rc_trim) && $stable(watchdog_enable) && $stable(brownout_level)) else $error("options moved");
	chk_pin_released: assert property (cfg_valid && $past(cfg_valid, 3) && osc_mode_select != 3'h2 |->
		osc_in_pin_oe_n) else $error("osc pin driven outside clock out mode");
	chk_wait_answer: assert property (clock_en && (avs_read || avs_write) && avs_waitrequest |=>
		!avs_waitrequest) else $error("bus answer late");
endmodule : crod_top_props

bind crod_top crod_top_props crod_top_props_i (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .opt_word0(opt_word0),
	.opt_word1(opt_word1), .cfg_valid(cfg_valid), .run_mode(run_mode), .low_power(low_power),
	.brownout_level(brownout_level), .brownout_enable(brownout_enable), .watchdog_enable(watchdog_enable),
	.sub_clock_32k(sub_clock_32k), .sub_clock_freq_khz(sub_clock_freq_khz), .internal_rc_trim(internal_rc_trim),
	.internal_rc_freq_select(internal_rc_freq_select), .main_clock_freq_khz(main_clock_freq_khz),
	.osc_mode_select(osc_mode_select), .internal_rc_mode(internal_rc_mode), .crystal_low_mode(crystal_low_mode),
	.osc_in_gpio(osc_in_gpio), .osc_in_pin_oe_n(osc_in_pin_oe_n));

/* File: test/crod_top_tb.sv */
// self-checking bench for the clock and reset option decoder
`timescale 1ns/1ps
module crod_top_tb;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [14:0] opt_word0 = 15'h27ff;
	logic [14:0] opt_word1 = 15'h7fe7;
	logic        cycle_length_select = 1'b0;
	logic        shared_pin_in = 1'b1;
	logic        clock_en = 1'b1;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, cfg_valid, low_power, brownout_enable, ext_reset_n, shared_port_bit;
	logic        watchdog_enable, sub_clock_32k, internal_rc_mode, crystal_low_mode, osc_in_gpio;
	logic        instr_clk, osc_in_pin_out, osc_in_pin_oe_n;
	logic [1:0]  run_mode, brownout_level, internal_rc_freq_select;
	logic [15:0] sub_clock_freq_khz, main_clock_freq_khz;
	logic [5:0]  internal_rc_trim;
	logic [2:0]  osc_mode_select;
	logic [31:0] lfsr_r = 32'hdcf3_fc3d;
	int          mismatches = 0;
	int          tests_run = 0;
	wire  [53:0] dec = {run_mode, low_power, brownout_level, brownout_enable, watchdog_enable, sub_clock_32k,
		sub_clock_freq_khz, internal_rc_trim, internal_rc_freq_select, main_clock_freq_khz, osc_mode_select,
		internal_rc_mode, crystal_low_mode, osc_in_gpio};

	// 50 mhz clock
	always #10 clock = ~clock;

	crod_top crod_top_i (.clock(clock), .reset_n(reset_n), .clock_en(clock_en), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .opt_word0(opt_word0),
		.opt_word1(opt_word1), .cycle_length_select(cycle_length_select), .shared_pin_in(shared_pin_in),
		.cfg_valid(cfg_valid), .run_mode(run_mode), .low_power(low_power), .brownout_level(brownout_level),
		.brownout_enable(brownout_enable), .ext_reset_n(ext_reset_n), .shared_port_bit(shared_port_bit),
		.watchdog_enable(watchdog_enable), .sub_clock_32k(sub_clock_32k), .sub_clock_freq_khz(sub_clock_freq_khz),
		.internal_rc_trim(internal_rc_trim), .internal_rc_freq_select(internal_rc_freq_select),
		.main_clock_freq_khz(main_clock_freq_khz), .osc_mode_select(osc_mode_select),
		.internal_rc_mode(internal_rc_mode), .crystal_low_mode(crystal_low_mode), .osc_in_gpio(osc_in_gpio),
		.instr_clk(instr_clk), .osc_in_pin_out(osc_in_pin_out), .osc_in_pin_oe_n(osc_in_pin_oe_n));

	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// reference decode of both words, laid out like dec; crystal modes report no main frequency
	function automatic logic [63:0] exp_dec(input logic [14:0] w0, input logic [14:0] w1);
		logic [15:0] f;
		f = w1[3] ? 16'h0000 : w1[6:5] == 2'h0 ? 16'h03e8 : w1[6:5] == 2'h1 ? 16'h1f40 :
			w1[6:5] == 2'h2 ? 16'h3e80 : 16'h0fa0;
		return {w0[10] ? 2'h0 : 2'h1, !w0[9], w0[8:7], w0[8:7] != 2'h3, !w0[5], !w1[13],
			w1[13] ? 16'h0010 : 16'h0020, w1[12:7], w1[6:5], f, w1[3:1], !w1[3], w1[3:1] == 3'h4,
			!w1[3] && w1[3:1] != 3'h2};
	endfunction : exp_dec

	// one bus transfer held until waitrequest is seen low; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		check(n, 2, "bus latency");
	endtask : bus

	// reset with new words; the wait also lets the pin filter settle on the idle level
	task automatic setup(input logic [14:0] w0, input logic [14:0] w1, input logic cyc);
		@(posedge clock);
		reset_n <= 1'b0;
		opt_word0 <= w0;
		opt_word1 <= w1;
		cycle_length_select <= cyc;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		repeat (50) @(posedge clock);
		check(cfg_valid, 1, "valid");
	endtask : setup

	task automatic verify(input logic [14:0] w0, input logic [14:0] w1, input logic cyc);
		logic [63:0] e;
		e = exp_dec(w0, w1);
		check(dec, e, "decode");
		check({ext_reset_n, shared_port_bit}, {1'b1, w0[6]}, "pin function");
		bus(1'b0, 8'h0c, 32'h0000_0000);
		check(rd, {cyc, !w0[6], !w0[5], w1[3:1], w0[8:7] != 2'h3, w1[3:1] == 3'h2, !w1[3],
			w0[3] && w0[10], 1'b1}, "status");
		bus(1'b0, 8'h10, 32'h0000_0000);
		check(rd, {e[45:30], e[21:6]}, "freq");
	endtask : verify

	// low pulse of n clocks on the shared pin; acc says whether it must pass the filter
	task automatic pulse(input int n, input logic acc);
		logic seen;
		seen = 1'b0;
		@(posedge clock);
		shared_pin_in <= 1'b0;
		for (int k = 0; k < n + 45; k++) begin
			@(posedge clock);
			if (k == n - 1) shared_pin_in <= 1'b1;
			if (ext_reset_n === 1'b0) seen = 1'b1;
		end
		check(seen, acc, "filter");
	endtask : pulse

	task complete_run;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// watchdog sized well beyond the few thousand cycles the sequence needs
	initial begin
		repeat (40000) @(posedge clock);
		check(0, 1, "timeout");
		complete_run();
	end

	// main sequence: random option sets, filter widths, clock out
	initial begin
		logic [14:0] w0, w1, fw0 [5], fw1 [5];
		logic        cyc, prev;
		int          fwid [5], tog;
		fw0 = '{15'h27bf, 15'h27af, 15'h27bf, 15'h27b7, 15'h23bf};
		fw1 = '{15'h7fe7, 15'h7fe7, 15'h7fe9, 15'h7fe7, 15'h7fe7};
		fwid = '{32, 8, 8, 0, 0};
		for (int i = 0; i < 16; i++) begin
			w0 = (i == 0) ? 15'h27ff : lfsr_r[14:0];
			w1 = (i == 0) ? 15'h7fe7 : lfsr_r[30:16];
			cyc = lfsr_r[31];
			lfsr_r = lfsr_next(lfsr_next(lfsr_r));
			setup(w0, w1, cyc);
			verify(w0, w1, cyc);
			opt_word0 <= ~w0;
			opt_word1 <= ~w1;
			cycle_length_select <= !cyc;
			repeat (8) @(posedge clock);
			verify(w0, w1, cyc);
		end
		for (int i = 0; i < 5; i++) begin
			setup(fw0[i], fw1[i], 1'b0);
			if (fwid[i] > 0) begin
				pulse(fwid[i] - 2, 1'b0);
				pulse(fwid[i] + 2, 1'b1);
			end else begin
				pulse(2, 1'b1);
			end
		end
		// idle and sleep bypass the filter as well, so a two clock pulse reaches the reset pin
		for (int m = 2; m < 4; m++) begin
			bus(1'b1, 8'h08, m);
			bus(1'b0, 8'h08, 32'h0000_0000);
			check(rd, m, "mode readback");
			pulse(2, 1'b1);
		end
		// software back to normal mode re-arms the 32 clock filter; read-only and unmapped places
		bus(1'b1, 8'h08, 32'h0000_0000);
		bus(1'b0, 8'h08, 32'h0000_0000);
		check(rd, 32'h0000_0000, "mode readback");
		pulse(2, 1'b0);
		bus(1'b1, 8'h00, 32'h0000_0000);
		bus(1'b0, 8'h00, 32'h0000_0000);
		check(rd, {17'h0_0000, 15'h23bf}, "word0 read only");
		bus(1'b0, 8'h14, 32'h0000_0000);
		check(rd, 32'h0000_0000, "unmapped");
		for (int i = 0; i < 4; i++) begin
			setup(15'h27ff, i[1] ? 15'h7fe5 : 15'h7fe4, i[0]);
			tog = 0;
			prev = instr_clk;
			repeat (16) begin
				@(posedge clock);
				check({osc_in_pin_out, osc_in_pin_oe_n}, i[1] ? {prev, 1'b0} : {1'b0, prev}, "clock out");
				tog += (instr_clk !== prev);
				prev = instr_clk;
			end
			check(tog, i[0] ? 8 : 16, "cycle length");
		end
		// clock enable low must freeze the cycle clock
		clock_en <= 1'b0;
		@(posedge clock);
		tog = 0;
		prev = instr_clk;
		repeat (6) begin
			@(posedge clock);
			tog += (instr_clk !== prev);
		end
		check(tog, 0, "frozen");
		clock_en <= 1'b1;
		complete_run();
	end
endmodule : crod_top_tb
